// ---- verilog/tic_core.sv ----
// Timer interrupt controller and CPU flags register of the MCU core.
// Assumes the sequencer, stack and ALU share i_clk; only the halt wake
// input comes from outside the clock domain.
//
// Operation
// - Timer A overflow sets request flag at irq_control bit 5.
// - Timer A flag, enables, stack not full: call to vector 08H.
// - Acknowledge clears the serviced request flag and the master enable.
// - Timer B mirrors timer A: enable bit 3, request flag bit 6.
// - Both pending: timer A first (08H), then timer B (0CH).
// - No acknowledge while stack full; resume after stack pointer decrements.
// - With master enable cleared, new requests only set their flags.
// - Software re-enabling master and source enables allows nested interrupts.
// - Return from interrupt sets master enable; plain return leaves it.
// - Only program counter is pushed; cpu_flags is never saved.
// - Requests between two phase-two pulses become eligible on the later pulse and are serviced at the next instruction boundary.
// - Request flag stays set until serviced or cleared by software.
// - irq_control: master enable bit 0, timer A enable bit 2; 1,4,7 zero.
// - Every interrupt source wakes the device from halt.
// - Carry: add carry or subtract no-borrow; rotate-through-carry updates it.
// - Half carry: low-nibble carry in add, no nibble borrow in subtract.
// - Zero flag set when arithmetic or logical result is zero.
// - Overflow set when carry into top bit differs from carry out.
// - Power-down: cleared by power-up or watchdog clear, set by halt.
// - Time-out: cleared by power-up, watchdog clear or halt; set on time-out.
// - Writes change arithmetic flags only; bits 6 and 7 read zero.
// - Vector address lies within the currently selected program bank.
// - Return stack has eight levels; full when all eight are occupied.
`timescale 1ns/1ps
`include "tic_regs.svh"

module tic_core #(
  parameter int unsigned BANK_W = 2,
  parameter int unsigned STACK_LEVELS = `TIC_STACK_LEVELS
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  // Data memory register port
  input wire logic [`TIC_ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Timer overflows, one-cycle pulses
  input wire logic i_tmr_a_overflow,
  input wire logic i_tmr_b_overflow,
  // Sequencer
  input wire logic i_phase_two_pulse,
  input wire logic i_instr_boundary,
  input wire logic i_stack_full,
  input wire logic [BANK_W-1:0] i_bank,
  input wire logic i_return_from_interrupt,
  input wire logic i_return_from_subroutine,
  input wire logic i_halt_instruction,
  input wire logic i_watchdog_clear_instruction,
  input wire logic i_watchdog_timeout,
  input wire logic i_halted,
  input wire logic i_port_wake_async,
  output logic o_irq_call,
  output logic [BANK_W+`TIC_VEC_W-1:0] o_irq_vector,
  output logic o_wake,
  // ALU flag update
  input wire tic_pkg::tic_alu_op_type i_alu_op,
  input wire logic i_alu_sub,
  input wire logic [7:0] i_alu_a,
  input wire logic [7:0] i_alu_b,
  input wire logic i_alu_carry_in,
  input wire logic [7:0] i_alu_result,
  input wire logic i_rotate_carry,
  output logic [7:0] o_cpu_flags,
  output logic [7:0] o_irq_control
);

  // Refused at elaboration, before any logic is built
  if (BANK_W < 1 || BANK_W > 8) begin : g_bad_bank_w
    $error("tic_core: BANK_W out of range");
  end
  if (STACK_LEVELS != `TIC_STACK_LEVELS) begin : g_bad_stack_levels
    $error("tic_core: stack depth must be eight");
  end

  ////////////////////////////////////////////////////////////////////////
  // Register decode

  function automatic logic hit(input logic [`TIC_ADDR_W-1:0] a,
                               input logic [`TIC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic wr_flags;
  logic wr_irqc;
  logic rd_flags;
  logic rd_irqc;

  always_comb begin
    wr_flags = i_wr && hit(i_addr, `TIC_CPU_FLAGS_OFF);
    wr_irqc = i_wr && hit(i_addr, `TIC_IRQ_CONTROL_OFF);
    rd_flags = i_rd && hit(i_addr, `TIC_CPU_FLAGS_OFF);
    rd_irqc = i_rd && hit(i_addr, `TIC_IRQ_CONTROL_OFF);
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt control and arbitration

  logic master_irq_enable_q;
  logic master_irq_enable_d;
  logic tmr_a_irq_enable_q;
  logic tmr_a_irq_enable_d;
  logic tmr_b_irq_enable_q;
  logic tmr_b_irq_enable_d;
  logic tmr_a_request_flag_q;
  logic tmr_a_request_flag_d;
  logic tmr_b_request_flag_q;
  logic tmr_b_request_flag_d;
  // Requests latched at a phase-two pulse; eligible from then on
  logic tmr_a_sampled_q;
  logic tmr_a_sampled_d;
  logic tmr_b_sampled_q;
  logic tmr_b_sampled_d;
  logic irq_call_q;
  logic irq_call_d;
  logic [BANK_W+`TIC_VEC_W-1:0] irq_vector_q;
  logic [BANK_W+`TIC_VEC_W-1:0] irq_vector_d;
  logic wake_q;
  logic wake_d;
  logic port_wake;
  tic_pkg::tic_src_type grant;

  tic_sync u_port_wake_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async(i_port_wake_async),
    .o_level(port_wake)
  );

  always_comb begin
    master_irq_enable_d = master_irq_enable_q;
    tmr_a_irq_enable_d = tmr_a_irq_enable_q;
    tmr_b_irq_enable_d = tmr_b_irq_enable_q;
    tmr_a_request_flag_d = tmr_a_request_flag_q;
    tmr_b_request_flag_d = tmr_b_request_flag_q;
    tmr_a_sampled_d = tmr_a_sampled_q && tmr_a_request_flag_q;
    tmr_b_sampled_d = tmr_b_sampled_q && tmr_b_request_flag_q;
    irq_call_d = 1'b0;
    irq_vector_d = irq_vector_q;
    grant = tic_pkg::TIC_SRC_NONE;

    // Flags become eligible on the phase-two pulse after they rise
    if (i_phase_two_pulse) begin
      tmr_a_sampled_d = tmr_a_request_flag_q;
      tmr_b_sampled_d = tmr_b_request_flag_q;
    end

    // Acknowledge needs the master enable, source enable and room on the stack
    if (master_irq_enable_q && i_instr_boundary && !i_stack_full && !i_halted) begin
      if (tmr_a_sampled_q && tmr_a_request_flag_q && tmr_a_irq_enable_q) begin
        grant = tic_pkg::TIC_SRC_TMR_A;
      end else if (tmr_b_sampled_q && tmr_b_request_flag_q && tmr_b_irq_enable_q) begin
        grant = tic_pkg::TIC_SRC_TMR_B;
      end
    end

    // Software writes first; hardware events below override them
    if (wr_irqc) begin
      master_irq_enable_d = i_wdata[`TIC_MASTER_EN_BIT];
      tmr_a_irq_enable_d = i_wdata[`TIC_TMR_A_EN_BIT];
      tmr_b_irq_enable_d = i_wdata[`TIC_TMR_B_EN_BIT];
      tmr_a_request_flag_d = i_wdata[`TIC_TMR_A_REQ_BIT];
      tmr_b_request_flag_d = i_wdata[`TIC_TMR_B_REQ_BIT];
    end

    if (i_return_from_interrupt) begin
      master_irq_enable_d = 1'b1;
    end

    case (grant)
      tic_pkg::TIC_SRC_TMR_A: begin
        irq_call_d = 1'b1;
        // Bank bits kept, offset replaced by the vector
        irq_vector_d = {i_bank, `TIC_TMR_A_VECTOR};
        tmr_a_request_flag_d = 1'b0;
        tmr_a_sampled_d = 1'b0;
        master_irq_enable_d = 1'b0;
      end
      tic_pkg::TIC_SRC_TMR_B: begin
        irq_call_d = 1'b1;
        irq_vector_d = {i_bank, `TIC_TMR_B_VECTOR};
        tmr_b_request_flag_d = 1'b0;
        tmr_b_sampled_d = 1'b0;
        master_irq_enable_d = 1'b0;
      end
      default: begin
      end
    endcase

    // A new overflow wins over any clear in the same cycle
    if (i_tmr_a_overflow) begin
      tmr_a_request_flag_d = 1'b1;
    end
    if (i_tmr_b_overflow) begin
      tmr_b_request_flag_d = 1'b1;
    end

    // Any newly raised request or port stimulus ends halt
    wake_d = i_halted && (i_tmr_a_overflow || i_tmr_b_overflow || port_wake);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      master_irq_enable_q <= 1'b0;
      tmr_a_irq_enable_q <= 1'b0;
      tmr_b_irq_enable_q <= 1'b0;
      tmr_a_request_flag_q <= 1'b0;
      tmr_b_request_flag_q <= 1'b0;
      tmr_a_sampled_q <= 1'b0;
      tmr_b_sampled_q <= 1'b0;
      irq_call_q <= 1'b0;
      irq_vector_q <= '0;
      wake_q <= 1'b0;
    end else begin
      master_irq_enable_q <= master_irq_enable_d;
      tmr_a_irq_enable_q <= tmr_a_irq_enable_d;
      tmr_b_irq_enable_q <= tmr_b_irq_enable_d;
      tmr_a_request_flag_q <= tmr_a_request_flag_d;
      tmr_b_request_flag_q <= tmr_b_request_flag_d;
      tmr_a_sampled_q <= tmr_a_sampled_d;
      tmr_b_sampled_q <= tmr_b_sampled_d;
      irq_call_q <= irq_call_d;
      irq_vector_q <= irq_vector_d;
      wake_q <= wake_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // CPU flags

  logic carry_q;
  logic carry_d;
  logic half_carry_flag_q;
  logic half_carry_flag_d;
  logic zero_q;
  logic zero_d;
  logic overflow_flag_q;
  logic overflow_flag_d;
  logic power_down_flag_q;
  logic power_down_flag_d;
  logic timeout_flag_q;
  logic timeout_flag_d;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] sum8;
  logic [7:0] opnd_b;

  always_comb begin
    carry_d = carry_q;
    half_carry_flag_d = half_carry_flag_q;
    zero_d = zero_q;
    overflow_flag_d = overflow_flag_q;
    power_down_flag_d = power_down_flag_q;
    timeout_flag_d = timeout_flag_q;
    // Subtraction as a + ~b + cin, so a carry out means no borrow
    opnd_b = i_alu_sub ? ~i_alu_b : i_alu_b;
    sum9 = {1'b0, i_alu_a} + {1'b0, opnd_b} + {8'h00, i_alu_carry_in};
    sum5 = {1'b0, i_alu_a[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, i_alu_carry_in};
    sum8 = {1'b0, i_alu_a[6:0]} + {1'b0, opnd_b[6:0]} + {7'h00, i_alu_carry_in};

    // Plain writes touch only the four arithmetic flags
    if (wr_flags) begin
      carry_d = i_wdata[`TIC_CARRY_BIT];
      half_carry_flag_d = i_wdata[`TIC_HALF_CARRY_BIT];
      zero_d = i_wdata[`TIC_ZERO_BIT];
      overflow_flag_d = i_wdata[`TIC_OVERFLOW_BIT];
    end

    case (i_alu_op)
      tic_pkg::TIC_ALU_ARITH: begin
        carry_d = sum9[8];
        half_carry_flag_d = sum5[4];
        zero_d = (i_alu_result == 8'h00);
        overflow_flag_d = sum8[7] ^ sum9[8];
      end
      tic_pkg::TIC_ALU_LOGIC: begin
        zero_d = (i_alu_result == 8'h00);
      end
      tic_pkg::TIC_ALU_ROTATE: begin
        carry_d = i_rotate_carry;
      end
      default: begin
      end
    endcase

    // Halt and watchdog clear are distinct instructions, never together
    if (i_watchdog_clear_instruction) begin
      power_down_flag_d = 1'b0;
      timeout_flag_d = 1'b0;
    end
    if (i_halt_instruction) begin
      power_down_flag_d = 1'b1;
      timeout_flag_d = 1'b0;
    end
    if (i_watchdog_timeout) begin
      timeout_flag_d = 1'b1;
    end
  end

  // Power-up reset clears both sticky flags; other resets are the
  // sequencer's business and leave them alone
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      carry_q <= 1'b0;
      half_carry_flag_q <= 1'b0;
      zero_q <= 1'b0;
      overflow_flag_q <= 1'b0;
      power_down_flag_q <= 1'b0;
      timeout_flag_q <= 1'b0;
    end else begin
      carry_q <= carry_d;
      half_carry_flag_q <= half_carry_flag_d;
      zero_q <= zero_d;
      overflow_flag_q <= overflow_flag_d;
      power_down_flag_q <= power_down_flag_d;
      timeout_flag_q <= timeout_flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data and mirrors

  logic [7:0] flags_img;
  logic [7:0] irqc_img;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] flags_out_q;
  logic [7:0] irqc_out_q;

  always_comb begin
    flags_img = 8'h00;
    flags_img[`TIC_CARRY_BIT] = carry_q;
    flags_img[`TIC_HALF_CARRY_BIT] = half_carry_flag_q;
    flags_img[`TIC_ZERO_BIT] = zero_q;
    flags_img[`TIC_OVERFLOW_BIT] = overflow_flag_q;
    flags_img[`TIC_POWER_DOWN_BIT] = power_down_flag_q;
    flags_img[`TIC_TIMEOUT_BIT] = timeout_flag_q;
    irqc_img = 8'h00;
    irqc_img[`TIC_MASTER_EN_BIT] = master_irq_enable_q;
    irqc_img[`TIC_TMR_A_EN_BIT] = tmr_a_irq_enable_q;
    irqc_img[`TIC_TMR_B_EN_BIT] = tmr_b_irq_enable_q;
    irqc_img[`TIC_TMR_A_REQ_BIT] = tmr_a_request_flag_q;
    irqc_img[`TIC_TMR_B_REQ_BIT] = tmr_b_request_flag_q;
    rdata_d = 8'h00;
    if (rd_flags) begin
      rdata_d = flags_img;
    end else if (rd_irqc) begin
      rdata_d = irqc_img;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= 8'h00;
      flags_out_q <= 8'h00;
      irqc_out_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
      flags_out_q <= flags_img;
      irqc_out_q <= irqc_img;
    end
  end

  // For a call only the strobe and vector go out; the sequencer pushes the
  // program counter alone and never the flags
  assign o_irq_call = irq_call_q;
  assign o_irq_vector = irq_vector_q;
  assign o_wake = wake_q;
  assign o_rdata = rdata_q;
  assign o_cpu_flags = flags_out_q;
  assign o_irq_control = irqc_out_q;

endmodule : tic_core

// ---- verilog/tic_regs.svh ----
// Register offsets, field positions, reset values and vectors of the timer
// interrupt and status flag block.
// Assumes a data memory bus with 8-bit registers at byte offsets.
`ifndef TIC_REGS_SVH
`define TIC_REGS_SVH

`define TIC_ADDR_W 8
`define TIC_CPU_FLAGS_OFF 8'h0A
`define TIC_IRQ_CONTROL_OFF 8'h0B

// cpu_flags fields
`define TIC_CARRY_BIT 0
`define TIC_HALF_CARRY_BIT 1
`define TIC_ZERO_BIT 2
`define TIC_OVERFLOW_BIT 3
`define TIC_POWER_DOWN_BIT 4
`define TIC_TIMEOUT_BIT 5
`define TIC_CPU_FLAGS_WMASK 8'h0F
`define TIC_CPU_FLAGS_RMASK 8'h3F
`define TIC_CPU_FLAGS_RESET 8'h00

// irq_control fields
`define TIC_MASTER_EN_BIT 0
`define TIC_TMR_A_EN_BIT 2
`define TIC_TMR_B_EN_BIT 3
`define TIC_TMR_A_REQ_BIT 5
`define TIC_TMR_B_REQ_BIT 6
`define TIC_IRQ_CONTROL_RMASK 8'h6D
`define TIC_IRQ_CONTROL_RESET 8'h00

// Vector offsets within the active program bank
`define TIC_VEC_W 13
`define TIC_TMR_A_VECTOR 13'h0008
`define TIC_TMR_B_VECTOR 13'h000C

`define TIC_STACK_LEVELS 8

`endif

// ---- verilog/tic_pkg.sv ----
// Types of the timer interrupt and status flag block.
// Assumes tic_regs.svh supplies all numeric constants.
package tic_pkg;

  typedef enum logic [1:0] {
    TIC_SRC_NONE,
    TIC_SRC_TMR_A,
    TIC_SRC_TMR_B
  } tic_src_type;

  typedef enum logic [1:0] {
    TIC_ALU_NONE,
    TIC_ALU_ARITH,
    TIC_ALU_LOGIC,
    TIC_ALU_ROTATE
  } tic_alu_op_type;

endpackage : tic_pkg

// ---- verilog/tic_sync.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to i_clk; the output changes once the
// second and third stages agree.
`timescale 1ns/1ps

module tic_sync (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_async,
  output logic o_level
);

  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic level_q;
  logic level_d;

  always_comb begin
    stage_d = {stage_q[1:0], i_async};
    // Stage 0 is read only by stage 1
    level_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : level_q;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stage_q <= 3'h0;
      level_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  assign o_level = level_q;

endmodule : tic_sync

// ---- testbench/tic_core_assertions.sv ----
// Checker for the timer interrupt and CPU flags block.
// Assumes it is bound to tic_core and sees only that module's ports.
`timescale 1ns/1ps
`include "tic_regs.svh"

module tic_core_assertions #(
  parameter int unsigned BANK_W = 2
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [`TIC_ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_instr_boundary,
  input wire logic i_stack_full,
  input wire logic i_halted,
  input wire logic [BANK_W-1:0] i_bank,
  input wire logic i_halt_instruction,
  input wire logic i_watchdog_clear_instruction,
  input wire logic i_watchdog_timeout,
  input wire tic_pkg::tic_alu_op_type i_alu_op,
  input wire logic i_alu_sub,
  input wire logic [7:0] i_alu_a,
  input wire logic [7:0] i_alu_b,
  input wire logic i_alu_carry_in,
  input wire logic [7:0] i_alu_result,
  input wire logic i_rotate_carry,
  input wire logic o_irq_call,
  input wire logic [BANK_W+`TIC_VEC_W-1:0] o_irq_vector,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] o_cpu_flags
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  ////////////////////////////////////////
  // Reference flags, worked out from the operands; only the zero flag uses the result
  logic [7:0] opb;
  logic [8:0] sum;
  logic [4:0] lo4;
  logic ov_ref;
  logic [3:0] exp_flags;
  assign opb = i_alu_sub ? ~i_alu_b : i_alu_b;
  assign sum = {1'h0, i_alu_a} + {1'h0, opb} + {8'h00, i_alu_carry_in};
  assign lo4 = {1'h0, i_alu_a[3:0]} + {1'h0, opb[3:0]} + {4'h0, i_alu_carry_in};
  // Signed overflow by operand and result signs, independent of carry chains
  assign ov_ref = (i_alu_a[7] == opb[7]) && (sum[7] != i_alu_a[7]);
  assign exp_flags = {ov_ref, i_alu_result == 8'h00, lo4[4], sum[8]};

  ////////////////////////////////////////
  AST_CALL_GATED: assert property (
    o_irq_call |-> $past(i_instr_boundary && !i_stack_full && !i_halted))
    else $error("Call outside boundary or with stack full");
  AST_CALL_SINGLE: assert property (
    o_irq_call |=> !o_irq_call)
    else $error("Back to back calls");
  AST_VECTOR_BANK: assert property (
    o_irq_call |-> o_irq_vector[BANK_W+12:13] == $past(i_bank))
    else $error("Vector outside active bank");
  AST_VECTOR_OFFSET: assert property (
    o_irq_call |-> o_irq_vector[12:0] inside {`TIC_TMR_A_VECTOR, `TIC_TMR_B_VECTOR})
    else $error("Bad vector offset");
  AST_CTRL_UNUSED: assert property (
    i_rd && i_addr == `TIC_IRQ_CONTROL_OFF |=> (o_rdata & 8'h92) == 8'h00)
    else $error("Unused control bit reads one");
  AST_FLAGS_UNUSED: assert property (
    i_rd && i_addr == `TIC_CPU_FLAGS_OFF |=> o_rdata[7:6] == 2'h0)
    else $error("Unused flag bit reads one");
  AST_WRITE_KEEPS: assert property (
    i_wr && i_addr == `TIC_CPU_FLAGS_OFF && !i_halt_instruction
    && !i_watchdog_clear_instruction && !i_watchdog_timeout
    |=> ##1 o_cpu_flags[5:4] == $past(o_cpu_flags[5:4]))
    else $error("Write changed power-down or time-out");
  AST_HALT_FLAGS: assert property (
    i_halt_instruction && !i_watchdog_timeout && !i_watchdog_clear_instruction
    |=> ##1 o_cpu_flags[5:4] == 2'h1)
    else $error("Halt flags wrong");
  AST_TIMEOUT_SET: assert property (
    i_watchdog_timeout && !i_watchdog_clear_instruction |=> ##1 o_cpu_flags[5])
    else $error("Time-out flag not set");
  AST_WDC_CLEAR: assert property (
    i_watchdog_clear_instruction && !i_watchdog_timeout && !i_halt_instruction
    |=> ##1 o_cpu_flags[5:4] == 2'h0)
    else $error("Watchdog clear left flags set");
  AST_ARITH_FLAGS: assert property (
    i_alu_op == tic_pkg::TIC_ALU_ARITH |=> ##1 o_cpu_flags[3:0] == $past(exp_flags, 2))
    else $error("Arithmetic flags wrong");
  AST_ROTATE_CARRY: assert property (
    i_alu_op == tic_pkg::TIC_ALU_ROTATE |=> ##1 o_cpu_flags[0] == $past(i_rotate_carry, 2))
    else $error("Rotate carry wrong");
endmodule : tic_core_assertions

// ---- testbench/tic_seq_model.sv ----
// Sequencer and return stack model facing tic_core.
// Assumes one clock; vector calls and bench calls push, returns pop.
`timescale 1ns/1ps

module tic_seq_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_irq_call,
  input wire logic i_push,
  input wire logic i_pop,
  output logic o_phase_two_pulse,
  output logic o_instr_boundary,
  output logic o_stack_full
);
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic [3:0] depth_q;
  logic [3:0] depth_d;

  always_comb begin
    phase_d = phase_q + 2'h1;
    depth_d = depth_q;
    // A push on a full stack is ignored, so depth saturates at eight
    if ((i_irq_call || i_push) && depth_q < 4'h8) begin
      depth_d = depth_q + 4'h1;
    end else if (i_pop && depth_q != 4'h0) begin
      depth_d = depth_q - 4'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_q <= 2'h0;
      depth_q <= 4'h0;
    end else begin
      phase_q <= phase_d;
      depth_q <= depth_d;
    end
  end

  assign o_phase_two_pulse = phase_q == 2'h0;
  assign o_instr_boundary = phase_q == 2'h2;
  assign o_stack_full = depth_q == 4'h8;
endmodule : tic_seq_model

// ---- testbench/tic_core_tb_top.sv ----
// Self-checking bench for tic_core with a sequencer and stack model.
// Assumes tic_pkg, the model and the checker are compiled first.
`timescale 1ns/1ps
`include "tic_regs.svh"

module tic_core_tb_top;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, alu_a = 8'h00, alu_b = 8'h00, alu_res = 8'h00;
  logic wr = 1'h0, rd = 1'h0, ovf_a = 1'h0, ovf_b = 1'h0, return_from_interrupt = 1'h0, ret = 1'h0;
  logic halt = 1'h0, wdc = 1'h0, wdt = 1'h0, halted = 1'h0, pwake = 1'h0, push = 1'h0;
  logic sub = 1'h0, cin = 1'h0, rcar = 1'h0;
  logic [1:0] bank = 2'h2;
  tic_pkg::tic_alu_op_type alu_op = tic_pkg::TIC_ALU_NONE;
  logic p2, bnd, sfull, call, wake;
  logic [14:0] vec;
  logic [7:0] rdata, flags, irqc;
  int fails = 0;
  int num_checks = 0;

  always #2.5 clk = ~clk;

  tic_core #(.BANK_W(2), .STACK_LEVELS(8)) i_dut (
    .i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
    .o_rdata(rdata), .i_tmr_a_overflow(ovf_a), .i_tmr_b_overflow(ovf_b),
    .i_phase_two_pulse(p2), .i_instr_boundary(bnd), .i_stack_full(sfull), .i_bank(bank),
    .i_return_from_interrupt(return_from_interrupt), .i_return_from_subroutine(ret),
    .i_halt_instruction(halt), .i_watchdog_clear_instruction(wdc),
    .i_watchdog_timeout(wdt), .i_halted(halted), .i_port_wake_async(pwake),
    .o_irq_call(call), .o_irq_vector(vec), .o_wake(wake), .i_alu_op(alu_op),
    .i_alu_sub(sub), .i_alu_a(alu_a), .i_alu_b(alu_b), .i_alu_carry_in(cin),
    .i_alu_result(alu_res), .i_rotate_carry(rcar), .o_cpu_flags(flags), .o_irq_control(irqc));

  tic_seq_model i_model (.i_clk(clk), .i_rstn(rstn), .i_irq_call(call), .i_push(push),
    .i_pop(ret | return_from_interrupt), .o_phase_two_pulse(p2), .o_instr_boundary(bnd), .o_stack_full(sfull));

  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
    // Mirrors are captured at the same edge as the read data
    if (a == `TIC_IRQ_CONTROL_OFF) begin
      chk({8'h00, irqc}, {8'h00, exp});
    end else if (a == `TIC_CPU_FLAGS_OFF) begin
      chk({8'h00, flags}, {8'h00, exp});
    end
  endtask : rd_reg

  // One-cycle pulses: push, ret, return_from_interrupt, halt, wdc, wdt, ovf_b, ovf_a
  task automatic strobe(input logic [7:0] m);
    @(posedge clk);
    {push, ret, return_from_interrupt, halt, wdc, wdt, ovf_b, ovf_a} <= m;
    @(posedge clk);
    {push, ret, return_from_interrupt, halt, wdc, wdt, ovf_b, ovf_a} <= 8'h00;
  endtask : strobe

  task automatic alu(input tic_pkg::tic_alu_op_type op, input logic [7:0] a, b, res,
                     input logic s, c, r);
    @(posedge clk);
    alu_op <= op;
    alu_a <= a;
    alu_b <= b;
    alu_res <= res;
    sub <= s;
    cin <= c;
    rcar <= r;
    @(posedge clk);
    alu_op <= tic_pkg::TIC_ALU_NONE;
  endtask : alu

  // Waits for a wake pulse (sel) or a vector call, which is only one cycle wide
  task automatic wait_hi(input logic sel, input logic [14:0] exp);
    int n;
    n = 0;
    #1;
    while ((sel ? wake : call) !== 1'h1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({15'h0000, n == 40}, 16'h0000);
    if (n == 40) begin
      end_sim();
    end else if (!sel) begin
      chk({1'h0, vec}, {1'h0, exp});
    end
  endtask : wait_hi

  task automatic no_call(input int cyc);
    repeat (cyc) begin
      @(posedge clk);
      #1;
      chk({15'h0000, call}, 16'h0000);
    end
  endtask : no_call

  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    rd_reg(8'h0A, 8'h00);
    rd_reg(8'h0B, 8'h00);
    rd_reg(8'h30, 8'h00);
    wr_reg(8'h0B, 8'h9E);
    rd_reg(8'h0B, 8'h0C);
    wr_reg(8'h0A, 8'hFF);
    rd_reg(8'h0A, 8'h0F);
    strobe(8'h04);
    rd_reg(8'h0A, 8'h2F);
    strobe(8'h10);
    rd_reg(8'h0A, 8'h1F);
    strobe(8'h04);
    wr_reg(8'h0A, 8'h00);
    rd_reg(8'h0A, 8'h30);
    strobe(8'h08);
    rd_reg(8'h0A, 8'h00);
    alu(tic_pkg::TIC_ALU_ARITH, 8'h7F, 8'h01, 8'h80, 1'h0, 1'h0, 1'h0);
    rd_reg(8'h0A, 8'h0A);
    alu(tic_pkg::TIC_ALU_ARITH, 8'hFF, 8'h01, 8'h00, 1'h0, 1'h0, 1'h0);
    rd_reg(8'h0A, 8'h07);
    alu(tic_pkg::TIC_ALU_ARITH, 8'h05, 8'h03, 8'h02, 1'h1, 1'h1, 1'h0);
    rd_reg(8'h0A, 8'h03);
    alu(tic_pkg::TIC_ALU_ARITH, 8'h03, 8'h05, 8'hFE, 1'h1, 1'h1, 1'h0);
    rd_reg(8'h0A, 8'h00);
    alu(tic_pkg::TIC_ALU_LOGIC, 8'hF0, 8'h0F, 8'h00, 1'h0, 1'h0, 1'h0);
    rd_reg(8'h0A, 8'h04);
    alu(tic_pkg::TIC_ALU_ROTATE, 8'h80, 8'h00, 8'h00, 1'h0, 1'h0, 1'h1);
    rd_reg(8'h0A, 8'h05);
    // Both timers at once: A first, B waits for the return
    wr_reg(8'h0B, 8'h0D);
    strobe(8'h03);
    wait_hi(1'h0, {2'h2, 13'h0008});
    no_call(8);
    rd_reg(8'h0B, 8'h4C);
    strobe(8'h20);
    wait_hi(1'h0, {2'h2, 13'h000C});
    strobe(8'h01);
    no_call(12);
    rd_reg(8'h0B, 8'h2C);
    wr_reg(8'h0B, 8'h2D);
    wait_hi(1'h0, {2'h2, 13'h0008});
    strobe(8'h40);
    rd_reg(8'h0B, 8'h0C);
    // Fill the return stack; the pending request must wait for a pop
    repeat (7) strobe(8'h80);
    wr_reg(8'h0B, 8'h0D);
    strobe(8'h01);
    no_call(12);
    rd_reg(8'h0B, 8'h2D);
    strobe(8'h40);
    wait_hi(1'h0, {2'h2, 13'h0008});
    wr_reg(8'h0B, 8'h00);
    @(posedge clk);
    halted <= 1'h1;
    strobe(8'h02);
    wait_hi(1'h1, 15'h0000);
    @(posedge clk);
    pwake <= 1'h1;
    wait_hi(1'h1, 15'h0000);
    @(posedge clk);
    pwake <= 1'h0;
    halted <= 1'h0;
    end_sim();
  end
endmodule : tic_core_tb_top

bind tic_core tic_core_assertions #(.BANK_W(BANK_W)) i_chk (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_instr_boundary(i_instr_boundary),
  .i_stack_full(i_stack_full), .i_halted(i_halted), .i_bank(i_bank),
  .i_halt_instruction(i_halt_instruction),
  .i_watchdog_clear_instruction(i_watchdog_clear_instruction),
  .i_watchdog_timeout(i_watchdog_timeout), .i_alu_op(i_alu_op), .i_alu_sub(i_alu_sub),
  .i_alu_a(i_alu_a), .i_alu_b(i_alu_b), .i_alu_carry_in(i_alu_carry_in),
  .i_alu_result(i_alu_result), .i_rotate_carry(i_rotate_carry), .o_irq_call(o_irq_call),
  .o_irq_vector(o_irq_vector), .o_rdata(o_rdata), .o_cpu_flags(o_cpu_flags));
